// ==== rtl/input_conditioner.sv ====
// two-flop synchroniser with optional four-sample agreement filter
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
  parameter int DEPTH = timer16_pkg::FILTER_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw level and filter control
  input wire logic raw,
  input wire logic filter_en,
  // conditioned level
  output logic level
);

  logic sync_meta;
  logic sync_out;
  logic [DEPTH-1:0] samples;

  wire all_high = &samples;
  wire all_low = ~|samples;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta <= 1'b0;
      sync_out <= 1'b0;
      samples <= '0;
      level <= 1'b0;
    end else begin
      sync_meta <= raw;
      sync_out <= sync_meta;
      samples <= {samples[DEPTH-2:0], sync_out};
      // the filter only moves once every sample in the window agrees
      if (!filter_en)
        level <= sync_out;
      else if (all_high || all_low)
        level <= samples[DEPTH-1];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/timer16_counter_and_capture.sv ====
// 16-bit timer counter with input capture behind an axi4-lite slave
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_and_capture (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [timer16_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [timer16_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [timer16_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [timer16_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // capture and external tick inputs, asynchronous
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  input wire logic comparator_output,
  input wire logic ext_tick_pin,
  // interrupt requests and service acknowledges
  output logic overflow_irq,
  output logic capture_irq,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack
);

  logic [15:0] count_value;
  logic count_up;
  logic [15:0] capture_value;
  logic [15:0] compare_reg_a;
  logic [7:0] high_latch;
  logic [7:0] timer_control_a;
  logic [7:0] timer_control_b;
  logic [7:0] capture_source;
  logic overflow_flag;
  logic capture_flag;
  logic overflow_irq_enable;
  logic capture_irq_enable;
  logic [timer16_pkg::PRESCALE_W-1:0] prescale;
  logic ext_prev;
  logic capture_prev;
  logic aw_full;
  logic w_full;
  logic [7:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;

  timer16_pkg::timer_cfg_t cfg;
  timer16_pkg::mode_decode_t mode;

  assign cfg.waveform_mode_sel = {timer_control_b[timer16_pkg::CTRL_B_WGM_LSB +: 2],
                                  timer_control_a[timer16_pkg::CTRL_A_WGM_LSB +: 2]};
  assign cfg.tick_source_sel = timer_control_b[timer16_pkg::CTRL_B_CS_LSB +: 3];
  assign cfg.noise_filter_enable = timer_control_b[timer16_pkg::CTRL_B_NOISE_BIT];
  assign cfg.edge_rising = timer_control_b[timer16_pkg::CTRL_B_EDGE_BIT];
  assign cfg.capture_pin_select = capture_source[timer16_pkg::SRC_PIN_SEL_BIT];
  assign cfg.comparator_select = capture_source[timer16_pkg::SRC_CMP_SEL_BIT];
  assign cfg.soft_drive_en = capture_source[timer16_pkg::SRC_SOFT_EN_BIT];
  assign cfg.soft_level = capture_source[timer16_pkg::SRC_SOFT_LVL_BIT];

  // mode table: which top, which slope, where the overflow lands
  wire [3:0] wave_mode = cfg.waveform_mode_sel;
  wire top_is_cmpa = wave_mode inside {4'd4, 4'd9, 4'd11, 4'd15};
  wire top_is_fixed = ~wave_mode[3] & (wave_mode[1:0] != 2'd0);
  assign mode.dual_slope = wave_mode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11};
  assign mode.clear_at_top = wave_mode inside {4'd4, 4'd5, 4'd6, 4'd7, 4'd12, 4'd14, 4'd15};
  assign mode.ovf_at_top = wave_mode inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15};
  assign mode.capture_is_top = wave_mode inside {4'd8, 4'd10, 4'd12, 4'd14};
  assign mode.top_value = mode.capture_is_top ? capture_value
                        : top_is_cmpa ? compare_reg_a
                        : !top_is_fixed ? timer16_pkg::COUNT_MAX
                        : wave_mode[1:0] == 2'd1 ? timer16_pkg::TOP_8BIT
                        : wave_mode[1:0] == 2'd2 ? timer16_pkg::TOP_9BIT
                        : timer16_pkg::TOP_10BIT;

  logic [3:0] cond_raw;
  logic [3:0] cond_filter;
  logic [3:0] cond_level;
  // a port drive replaces the pin level just as the pad would see it
  assign cond_raw[0] = cfg.soft_drive_en ? cfg.soft_level : capture_pin_a;
  assign cond_raw[1] = capture_pin_b;
  assign cond_raw[2] = comparator_output;
  assign cond_raw[3] = ext_tick_pin;
  assign cond_filter = {1'b0, {3{cfg.noise_filter_enable}}};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cond
      input_conditioner #(.DEPTH(timer16_pkg::FILTER_DEPTH)) u_cond (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(cond_raw[gi]),
        .filter_en(cond_filter[gi]),
        .level(cond_level[gi])
      );
    end
  endgenerate

  wire [9:0] pre_masked_8 = prescale & timer16_pkg::PRE_MASK_8;
  wire [9:0] pre_masked_64 = prescale & timer16_pkg::PRE_MASK_64;
  wire [9:0] pre_masked_256 = prescale & timer16_pkg::PRE_MASK_256;
  wire ext_rise = cond_level[3] & ~ext_prev;
  wire ext_fall = ~cond_level[3] & ext_prev;
  logic timer_tick;
  always_comb begin
    case (timer16_pkg::tick_source_t'(cfg.tick_source_sel))
      timer16_pkg::TICK_STOP: timer_tick = 1'b0;
      timer16_pkg::TICK_DIV1: timer_tick = 1'b1;
      timer16_pkg::TICK_DIV8: timer_tick = pre_masked_8 == timer16_pkg::PRE_MASK_8;
      timer16_pkg::TICK_DIV64: timer_tick = pre_masked_64 == timer16_pkg::PRE_MASK_64;
      timer16_pkg::TICK_DIV256: timer_tick = pre_masked_256 == timer16_pkg::PRE_MASK_256;
      timer16_pkg::TICK_DIV1024: timer_tick = prescale == timer16_pkg::PRE_MASK_1024;
      timer16_pkg::TICK_EXT_FALL: timer_tick = ext_fall;
      timer16_pkg::TICK_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire ar_fire = arvalid & arready;
  wire wr_fire = aw_full & w_full & ~bvalid;
  wire wr_en = wr_fire & wstrb0_q;
  wire [7:0] raddr = araddr;
  wire wr_count_lo = wr_en && waddr_q == timer16_pkg::ADDR_COUNT_LO;
  wire wr_cap_lo = wr_en && waddr_q == timer16_pkg::ADDR_CAP_LO;
  wire wr_cmpa_lo = wr_en && waddr_q == timer16_pkg::ADDR_CMPA_LO;
  wire wr_hi = wr_en && (waddr_q == timer16_pkg::ADDR_COUNT_HI
                      || waddr_q == timer16_pkg::ADDR_CAP_HI
                      || waddr_q == timer16_pkg::ADDR_CMPA_HI);
  wire wr_ctrl_a = wr_en && waddr_q == timer16_pkg::ADDR_CTRL_A;
  wire wr_ctrl_b = wr_en && waddr_q == timer16_pkg::ADDR_CTRL_B;
  wire wr_flags = wr_en && waddr_q == timer16_pkg::ADDR_FLAGS;
  wire wr_irq_en = wr_en && waddr_q == timer16_pkg::ADDR_IRQ_EN;
  wire wr_cap_src = wr_en && waddr_q == timer16_pkg::ADDR_CAP_SRC;
  wire wr_mapped = waddr_q <= timer16_pkg::ADDR_CAP_SRC && waddr_q[1:0] == 2'b00;
  wire rd_mapped = raddr <= timer16_pkg::ADDR_CAP_SRC && raddr[1:0] == 2'b00;
  wire rd_count_lo = ar_fire && raddr == timer16_pkg::ADDR_COUNT_LO;
  wire rd_cap_lo = ar_fire && raddr == timer16_pkg::ADDR_CAP_LO;
  wire [15:0] written_word = {high_latch, wbyte_q};
  logic [7:0] rd_byte;
  always_comb begin
    case (raddr)
      timer16_pkg::ADDR_COUNT_LO: rd_byte = count_value[7:0];
      timer16_pkg::ADDR_COUNT_HI: rd_byte = high_latch;
      timer16_pkg::ADDR_CAP_LO: rd_byte = capture_value[7:0];
      timer16_pkg::ADDR_CAP_HI: rd_byte = high_latch;
      timer16_pkg::ADDR_CMPA_LO: rd_byte = compare_reg_a[7:0];
      timer16_pkg::ADDR_CMPA_HI: rd_byte = compare_reg_a[15:8];
      timer16_pkg::ADDR_CTRL_A: rd_byte = timer_control_a;
      timer16_pkg::ADDR_CTRL_B: rd_byte = timer_control_b;
      timer16_pkg::ADDR_FLAGS: rd_byte = 8'(overflow_flag) << timer16_pkg::FLAG_OVF_BIT
                                      | 8'(capture_flag) << timer16_pkg::FLAG_CAP_BIT;
      timer16_pkg::ADDR_IRQ_EN: rd_byte = 8'(overflow_irq_enable) << timer16_pkg::FLAG_OVF_BIT
                                       | 8'(capture_irq_enable) << timer16_pkg::FLAG_CAP_BIT;
      timer16_pkg::ADDR_CAP_SRC: rd_byte = capture_source;
      default: rd_byte = 8'h00;
    endcase
  end

  wire at_top = count_value == mode.top_value;
  wire at_bottom = count_value == timer16_pkg::COUNT_BOTTOM;
  logic [15:0] next_count;
  logic next_up;
  logic ovf_event;
  always_comb begin
    next_count = count_value;
    next_up = count_up;
    ovf_event = 1'b0;
    if (wr_count_lo) begin
      next_count = written_word;
    end else if (timer_tick) begin
      if (mode.dual_slope) begin
        if (count_up && count_value >= mode.top_value) begin
          next_up = 1'b0;
          next_count = count_value - 16'h0001;
        end else if (!count_up && at_bottom) begin
          next_up = 1'b1;
          next_count = count_value + 16'h0001;
          ovf_event = 1'b1;
        end else begin
          next_count = count_up ? count_value + 16'h0001 : count_value - 16'h0001;
        end
      end else begin
        next_up = 1'b1;
        next_count = (mode.clear_at_top && at_top) ? timer16_pkg::COUNT_BOTTOM
                                                   : count_value + 16'h0001;
        ovf_event = mode.ovf_at_top ? at_top
                                    : count_value == timer16_pkg::COUNT_MAX;
      end
    end
  end

  // the mux sits after the filters, so switching source can look like an edge
  wire pin_level = cfg.capture_pin_select ? cond_level[1] : cond_level[0];
  wire capture_level = cfg.comparator_select ? cond_level[2] : pin_level;
  wire capture_event = ~mode.capture_is_top
                     & (capture_level != capture_prev)
                     & (capture_level == cfg.edge_rising);
  // set wins over any clear in the same cycle
  wire ovf_clear = (wr_flags & wbyte_q[timer16_pkg::FLAG_OVF_BIT]) | overflow_irq_ack;
  wire cap_clear = (wr_flags & wbyte_q[timer16_pkg::FLAG_CAP_BIT]) | capture_irq_ack;
  wire next_ovf_flag = ovf_event | (overflow_flag & ~ovf_clear);
  wire next_cap_flag = capture_event | (capture_flag & ~cap_clear);
  wire next_aw_full = (aw_full & ~wr_fire) | aw_fire;
  wire next_w_full = (w_full & ~wr_fire) | w_fire;
  wire next_rvalid = ar_fire | (rvalid & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      waddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= timer16_pkg::RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= ~next_aw_full;
      wready <= ~next_w_full;
      if (aw_fire)
        waddr_q <= awaddr;
      if (w_fire) begin
        wbyte_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= timer16_pkg::RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_fire) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_mapped ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      high_latch <= 8'h00;
    else if (wr_hi)
      high_latch <= wbyte_q;
    else if (rd_count_lo)
      high_latch <= count_value[15:8];
    else if (rd_cap_lo)
      high_latch <= capture_value[15:8];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= timer16_pkg::COUNT_RESET;
      count_up <= 1'b1;
      capture_value <= timer16_pkg::COUNT_RESET;
      compare_reg_a <= timer16_pkg::COUNT_RESET;
      prescale <= '0;
      ext_prev <= 1'b0;
      capture_prev <= 1'b0;
    end else begin
      count_value <= next_count;
      count_up <= next_up;
      prescale <= prescale + 10'h001;
      ext_prev <= cond_level[3];
      capture_prev <= capture_level;
      if (capture_event)
        capture_value <= count_value;
      else if (wr_cap_lo && mode.capture_is_top)
        capture_value <= written_word;
      if (wr_cmpa_lo)
        compare_reg_a <= written_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_a <= timer16_pkg::CTRL_RESET;
      timer_control_b <= timer16_pkg::CTRL_RESET;
      capture_source <= timer16_pkg::CTRL_RESET;
      overflow_irq_enable <= 1'b0;
      capture_irq_enable <= 1'b0;
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      if (wr_ctrl_a)
        timer_control_a <= wbyte_q;
      if (wr_ctrl_b)
        timer_control_b <= wbyte_q;
      if (wr_cap_src)
        capture_source <= wbyte_q;
      if (wr_irq_en) begin
        overflow_irq_enable <= wbyte_q[timer16_pkg::FLAG_OVF_BIT];
        capture_irq_enable <= wbyte_q[timer16_pkg::FLAG_CAP_BIT];
      end
      overflow_flag <= next_ovf_flag;
      capture_flag <= next_cap_flag;
      overflow_irq <= next_ovf_flag & overflow_irq_enable;
      capture_irq <= next_cap_flag & capture_irq_enable;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/timer16_pkg.sv ====
// constants, register map and carrier types for the 16-bit timer with capture
package timer16_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // register byte addresses, one aligned word each, data in bits 7:0
  localparam logic [7:0] ADDR_COUNT_LO = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h04;
  localparam logic [7:0] ADDR_CAP_LO = 8'h08;
  localparam logic [7:0] ADDR_CAP_HI = 8'h0c;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_CTRL_A = 8'h18;
  localparam logic [7:0] ADDR_CTRL_B = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
  localparam logic [7:0] ADDR_CAP_SRC = 8'h28;

  // field positions
  localparam int CTRL_A_WGM_LSB = 0;
  localparam int CTRL_B_CS_LSB = 0;
  localparam int CTRL_B_WGM_LSB = 3;
  localparam int CTRL_B_EDGE_BIT = 6;
  localparam int CTRL_B_NOISE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 5;
  localparam int SRC_PIN_SEL_BIT = 0;
  localparam int SRC_CMP_SEL_BIT = 1;
  localparam int SRC_SOFT_EN_BIT = 2;
  localparam int SRC_SOFT_LVL_BIT = 3;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // fixed top values and counter limits
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  // prescaler taps: a tick fires when the masked prescaler is all ones
  localparam int PRESCALE_W = 10;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  // filter depth in samples
  localparam int FILTER_DEPTH = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TICK_STOP, TICK_DIV1, TICK_DIV8, TICK_DIV64,
    TICK_DIV256, TICK_DIV1024, TICK_EXT_FALL, TICK_EXT_RISE
  } tick_source_t;

  typedef struct packed {
    logic [3:0] waveform_mode_sel;
    logic [2:0] tick_source_sel;
    logic noise_filter_enable;
    logic edge_rising;
    logic capture_pin_select;
    logic comparator_select;
    logic soft_drive_en;
    logic soft_level;
  } timer_cfg_t;

  typedef struct packed {
    logic [15:0] top_value;
    logic dual_slope;
    logic clear_at_top;
    logic ovf_at_top;
    logic capture_is_top;
  } mode_decode_t;

endpackage

// ==== tb/capture_source.sv ====
// far-side model: capture pins, comparator level and external tick
`timescale 1ns/1ps
`default_nettype none
module capture_source (
  // clock
  input wire logic aclk,
  // levels toward the timer
  output var logic pin_a = 1'b0,
  output var logic pin_b = 1'b0,
  output var logic cmp_out = 1'b0,
  output var logic ext_tick = 1'b0
);
  task automatic drive(input logic a, input logic b);
    @(posedge aclk);
    pin_a <= a;
    pin_b <= b;
  endtask
  // short pulse on pin a, shorter than the filter's agreement span
  task automatic spike(input int n);
    @(posedge aclk);
    pin_a <= !pin_a;
    repeat (n) @(posedge aclk);
    pin_a <= !pin_a;
  endtask
  task automatic set_cmp(input logic c);
    @(posedge aclk);
    cmp_out <= c;
  endtask
endmodule
`default_nettype wire

// ==== tb/timer16_checker.sv ====
// port-level assertions for the timer bus and capture request
`timescale 1ns/1ps
`default_nettype none
module timer16_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [timer16_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  // capture side
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  input wire logic capture_irq,
  input wire logic capture_irq_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] prev_pins;
  logic [3:0] quiet;
  // an ack only clears for sure once no capture can still be in the pipeline
  always_ff @(posedge aclk) begin
    prev_pins <= {capture_pin_a, capture_pin_b};
    if (!aresetn || prev_pins != {capture_pin_a, capture_pin_b}) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  sequence wr_taken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_taken |=> rvalid)
    else $error("read answer late");
  chk_byte_lane: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data beyond one byte");
  chk_one_read: assert property (rvalid |-> !arready)
    else $error("second read accepted");
  chk_addr_refused: assert property (awvalid && awready |=> !awready)
    else $error("write address not held off");
  chk_data_refused: assert property (wvalid && wready |=> !wready)
    else $error("write data not held off");
  chk_resp_code: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
    else $error("bad write response");
  chk_ack_clears: assert property (capture_irq && capture_irq_ack && quiet == 4'hf
    |=> ##[0:1] !capture_irq)
    else $error("capture request not cleared by ack");
endmodule
bind timer16_counter_and_capture timer16_checker u_timer16_checker (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .arvalid, .arready, .rdata,
  .rvalid, .capture_pin_a, .capture_pin_b, .capture_irq, .capture_irq_ack);
`default_nettype wire

// ==== tb/timer16_counter_and_capture_bench.sv ====
// self-checking bench: bus, counter, capture, filter and top modes
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_and_capture_bench;
  localparam logic [7:0] CNT = timer16_pkg::ADDR_COUNT_LO;
  localparam logic [7:0] CAP = timer16_pkg::ADDR_CAP_LO;
  localparam logic [7:0] CTB = timer16_pkg::ADDR_CTRL_B;
  localparam logic [7:0] FLG = timer16_pkg::ADDR_FLAGS;
  localparam logic [7:0] SRC = timer16_pkg::ADDR_CAP_SRC;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, oack = 1'b0, cack = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, b;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid, oirq, cirq, pa, pb, pc, pt;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic [15:0] v;
  int err_count = 0, checks_done = 0, lat0, lat1;
  always #10 aclk = ~aclk;
  timer16_counter_and_capture u_timer16_counter_and_capture (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .capture_pin_a(pa),
    .capture_pin_b(pb), .comparator_output(pc), .ext_tick_pin(pt), .overflow_irq(oirq),
    .capture_irq(cirq), .overflow_irq_ack(oack), .capture_irq_ack(cack));
  capture_source u_capture_source (.aclk, .pin_a(pa), .pin_b(pb), .cmp_out(pc), .ext_tick(pt));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta || awready;
      tw = tw || wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    chk("rresp", er, rresp);
  endtask
  // low byte first on reads, high byte first on writes
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    rd(a, q[7:0]);
    rd(a + 8'h04, q[15:8]);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h04, d[15:8]);
    wr(a, d[7:0]);
  endtask
  task automatic wait_cap(output int n);
    n = 0;
    while (!cirq) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic t_counter;
    wr16(CNT, 16'h1234);
    repeat (8) @(posedge aclk);
    rd16(CNT, v);
    chk("stopped count", 16'h1234, v);
    wr(CNT + 8'h04, 8'h77);
    rd(CAP + 8'h04, b);
    chk("shared latch", 16'h0077, b);
    rd(8'h3c, b, 2'h2);
    wr(timer16_pkg::ADDR_CMPA_LO, 8'h11);
    rd(timer16_pkg::ADDR_CMPA_HI, b);
    chk("reused high byte", 16'h0077, b);
  endtask
  task automatic t_overflow;
    wr16(CNT, 16'hfff8);
    wr(CTB, 8'h01);
    repeat (16) @(posedge aclk);
    wr(CTB, 8'h00);
    rd16(CNT, v);
    chk("wrapped count", 1'b1, v > 16'h0007 && v < 16'h0040);
    rd(FLG, b);
    chk("overflow flag", 8'h01, b & 8'h01);
    chk("overflow irq", 1'b1, oirq);
    oack <= 1'b1;
    @(posedge aclk);
    oack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("overflow irq", 1'b0, oirq);
    wr(CTB, 8'h01);
    wr16(CNT, 16'h4000);
    wr(CTB, 8'h00);
    rd16(CNT, v);
    chk("written while counting", 1'b1, v > 16'h4000 && v < 16'h4040);
  endtask
  task automatic t_capture;
    wr(CTB, 8'h40);
    wr16(CNT, 16'h0abc);
    u_capture_source.drive(1'b1, 1'b0);
    wait_cap(lat0);
    rd16(CAP, v);
    chk("capture a", 16'h0abc, v);
    rd(FLG, b);
    chk("capture flag", 8'h20, b & 8'h20);
    wr(FLG, 8'h00);
    rd(FLG, b);
    chk("flag kept", 8'h20, b & 8'h20);
    wr(FLG, 8'h20);
    rd(FLG, b);
    chk("flag cleared", 8'h00, b & 8'h20);
    u_capture_source.drive(1'b1, 1'b1);
    wr(SRC, 8'h01);
    wr(CTB, 8'h00);
    wr(FLG, 8'h20);
    wr16(CNT, 16'h0def);
    u_capture_source.drive(1'b1, 1'b0);
    wait_cap(lat1);
    rd16(CAP, v);
    chk("capture b falling", 16'h0def, v);
    repeat (8) @(posedge aclk);
    cack <= 1'b1;
    @(posedge aclk);
    cack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("capture irq", 1'b0, cirq);
    wr(CTB, 8'h40);
    wr(SRC, 8'h04);
    wr(FLG, 8'h20);
    wr16(CNT, 16'h0246);
    wr(SRC, 8'h0c);
    wait_cap(lat1);
    rd16(CAP, v);
    chk("soft capture", 16'h0246, v);
    wr(SRC, 8'h02);
    wr(FLG, 8'h20);
    u_capture_source.set_cmp(1'b1);
    wait_cap(lat1);
    rd16(CAP, v);
    chk("comparator capture", 16'h0246, v);
    wr(SRC, 8'h00);
  endtask
  task automatic t_filter;
    wr(CTB, 8'hc0);
    u_capture_source.drive(1'b0, 1'b0);
    repeat (20) @(posedge aclk);
    wr(FLG, 8'h20);
    u_capture_source.spike(3);
    repeat (20) @(posedge aclk);
    chk("glitch", 1'b0, cirq);
    u_capture_source.drive(1'b1, 1'b0);
    wait_cap(lat1);
    chk("filter delay", lat0 + 4, lat1);
  endtask
  task automatic t_top;
    wr(CTB, 8'h00);
    wr16(CAP, 16'h5566);
    rd16(CAP, v);
    chk("capture write refused", 16'h0246, v);
    wr(CTB, 8'h58);
    wr16(CAP, 16'h5566);
    rd16(CAP, v);
    chk("capture as top", 16'h5566, v);
    wr(FLG, 8'h20);
    u_capture_source.drive(1'b0, 1'b0);
    u_capture_source.drive(1'b1, 1'b0);
    repeat (20) @(posedge aclk);
    rd(FLG, b);
    chk("capture off", 8'h00, b & 8'h20);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wr(timer16_pkg::ADDR_IRQ_EN, 8'h21);
    t_counter;
    t_overflow;
    t_capture;
    t_filter;
    t_top;
    print_verdict;
  end
endmodule
`default_nettype wire
